// *** ubd_params.svh ***
// register indices, field positions, event codes and reset values for bank 0
`ifndef UBD_PARAMS_SVH
`define UBD_PARAMS_SVH

// register indices; byte address is four times the index
`define UBD_IDX_DATA     4'h0
`define UBD_IDX_IRQEN    4'h1
`define UBD_IDX_EVID     4'h2
`define UBD_IDX_LINECTL  4'h3
`define UBD_IDX_MODEMCTL 4'h4
`define UBD_IDX_LINEST   4'h5
`define UBD_IDX_MODEMST  4'h6
`define UBD_IDX_SCRATCH  4'h7
`define UBD_IDX_MODE     4'h8
`define UBD_IDX_LAST     4'h8

// interrupt enable, event, mode and queue enable bit positions
`define UBD_IE_RX        0
`define UBD_IE_TX        1
`define UBD_IE_LS        2
`define UBD_IE_MS        3
`define UBD_IE_TXEMP     5
`define UBD_MODE_EXT     0
`define UBD_FIFOCTL_EN   0

// legacy event identification codes
`define UBD_EV_NONE      4'h1
`define UBD_EV_LS        4'h6
`define UBD_EV_RX        4'h4
`define UBD_EV_TOUT      4'hC
`define UBD_EV_TX        4'h2
`define UBD_EV_MS        4'h0

// reset values
`define UBD_RST_BYTE     8'h00
`define UBD_RST_WORD     32'h0000_0000

`endif

// *** ubd_pkg.sv ***
// types shared by the bank 0 register block
package ubd_pkg;

    typedef enum logic {
        UBD_LEGACY,
        UBD_EXTENDED
    } ubd_mode_e;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  irqen;
        ubd_mode_e   mode;
        logic        fifo_en;
        logic [7:0]  linectl;
        logic [7:0]  modemctl;
        logic [7:0]  scratch;
        logic [7:0]  rx_hold;
        logic        rx_full;
        logic [7:0]  tx_hold;
        logic        tx_valid;
        logic        thr_ev;
        logic        tx_push;
        logic        rx_pop;
        logic        irq;
    } ubd_state_s;

endpackage : ubd_pkg

// *** ubd_top.sv ***
// bank 0 data port, interrupt enables and event identification over APB
`timescale 1ns/1ps
`include "ubd_params.svh"

module ubd_top
    import ubd_pkg::*;
#(
    parameter int AW = 8
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // apb slave
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [AW-1:0] paddr_i,
    input  wire logic [31:0]   pwdata_i,
    input  wire logic [3:0]    pstrb_i,
    output logic               pready_o,
    output logic               pslverr_o,
    output logic [31:0]        prdata_o,
    // receiver side
    input  wire logic          rx_valid_i,
    input  wire logic [7:0]    rx_data_i,
    input  wire logic [7:0]    rx_fifo_data_i,
    output logic               rx_pop_o,
    // transmitter side
    input  wire logic          tx_ready_i,
    output logic               tx_valid_o,
    output logic               tx_push_o,
    output logic [7:0]         tx_data_o,
    // event sources
    input  wire logic          rx_level_i,
    input  wire logic          rx_timeout_i,
    input  wire logic          tx_low_i,
    input  wire logic          tx_empty_i,
    input  wire logic          line_status_event_i,
    input  wire logic          modem_status_event_i,
    input  wire logic [7:0]    line_status_i,
    input  wire logic [7:0]    modem_status_i,
    // control and interrupt
    output logic               fifo_enable_o,
    output logic               extended_o,
    output logic [7:0]         line_control_o,
    output logic [7:0]         modem_control_o,
    output logic               irq_o
);

    // the upper-bit decode needs at least one address bit above bit 5
    if (AW < 7) begin : g_aw_check
        $error("ubd_top: AW must be at least 7");
    end

    // ******************************************************
    // reset release
    // ******************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ******************************************************
    // decode and events
    // ******************************************************
    ubd_state_s q;
    ubd_state_s d;
    logic [3:0] idx;
    logic       bad;
    logic       acc_ph;
    logic       done;
    logic [7:0] pend;
    logic [7:0] en;
    logic [3:0] code;
    logic [7:0] rd_byte;
    logic       rx_ev;
    logic       tx_ev;
    logic       ext;

    assign ext    = (q.mode == UBD_EXTENDED);
    assign idx    = paddr_i[5:2];
    assign bad    = (paddr_i[AW-1:6] != '0) || (paddr_i[1:0] != 2'b00)
                    || (idx > `UBD_IDX_LAST);
    assign acc_ph = psel_i && penable_i;
    // one wait state: the edge with pready high completes the transfer
    assign done   = acc_ph && q.pready && !q.pslverr;

    // legacy holding register empty clears on identification read
    assign rx_ev = q.fifo_en ? (rx_level_i || rx_timeout_i) : q.rx_full;
    assign tx_ev = q.fifo_en ? tx_low_i : (ext ? !q.tx_valid : q.thr_ev);

    always_comb begin
        pend                = 8'h00;
        pend[`UBD_IE_RX]    = rx_ev;
        pend[`UBD_IE_TX]    = tx_ev;
        pend[`UBD_IE_LS]    = line_status_event_i;
        pend[`UBD_IE_MS]    = modem_status_event_i;
        pend[`UBD_IE_TXEMP] = ext && tx_empty_i;
    end
    assign en = q.irqen & pend;

    // in legacy mode only the highest enabled source is reported
    always_comb begin
        if (en[`UBD_IE_LS]) begin
            code = `UBD_EV_LS;
        end else if (en[`UBD_IE_RX]) begin
            code = (q.fifo_en && rx_timeout_i && !rx_level_i)
                   ? `UBD_EV_TOUT : `UBD_EV_RX;
        end else if (en[`UBD_IE_TX]) begin
            code = `UBD_EV_TX;
        end else if (en[`UBD_IE_MS]) begin
            code = `UBD_EV_MS;
        end else begin
            code = `UBD_EV_NONE;
        end
    end

    // ******************************************************
    // read mux
    // ******************************************************
    always_comb begin
        case (idx)
            `UBD_IDX_DATA: begin
                rd_byte = q.fifo_en ? rx_fifo_data_i : q.rx_hold;
            end
            `UBD_IDX_IRQEN: begin
                rd_byte = q.irqen;
            end
            `UBD_IDX_EVID: begin
                // extended: flat pending bits, regardless of enables
                rd_byte = ext ? pend
                              : {q.fifo_en, q.fifo_en, 2'b00, code};
            end
            `UBD_IDX_LINECTL: begin
                rd_byte = q.linectl;
            end
            `UBD_IDX_MODEMCTL: begin
                rd_byte = q.modemctl;
            end
            `UBD_IDX_LINEST: begin
                rd_byte = line_status_i;
            end
            `UBD_IDX_MODEMST: begin
                rd_byte = modem_status_i;
            end
            `UBD_IDX_SCRATCH: begin
                rd_byte = q.scratch;
            end
            `UBD_IDX_MODE: begin
                rd_byte = {7'h00, ext};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        d         = q;
        d.pready  = acc_ph && !q.pready;
        d.tx_push = 1'b0;
        d.rx_pop  = 1'b0;
        if (acc_ph && !q.pready) begin
            d.pslverr = bad;
            d.prdata  = bad ? `UBD_RST_WORD : {24'h00_0000, rd_byte};
        end else begin
            d.pslverr = 1'b0;
        end
        // read side effects
        if (done && !pwrite_i) begin
            if (idx == `UBD_IDX_DATA) begin
                d.rx_full = 1'b0;
                d.rx_pop  = q.fifo_en;
            end
            if (idx == `UBD_IDX_EVID && !ext && code == `UBD_EV_TX) begin
                d.thr_ev = 1'b0;
            end
        end
        // transmitter takes the holding byte
        if (!q.fifo_en && q.tx_valid && tx_ready_i) begin
            d.tx_valid = 1'b0;
        end
        if (done && pwrite_i && pstrb_i[0]) begin
            case (idx)
                `UBD_IDX_DATA: begin
                    d.tx_hold = pwdata_i[7:0];
                    d.thr_ev  = 1'b0;
                    if (q.fifo_en) begin
                        d.tx_push = 1'b1;
                    end else begin
                        d.tx_valid = 1'b1;
                    end
                end
                `UBD_IDX_IRQEN: begin
                    d.irqen = pwdata_i[7:0];
                end
                `UBD_IDX_EVID: begin
                    d.fifo_en = pwdata_i[`UBD_FIFOCTL_EN];
                end
                `UBD_IDX_LINECTL: begin
                    d.linectl = pwdata_i[7:0];
                end
                `UBD_IDX_MODEMCTL: begin
                    d.modemctl = pwdata_i[7:0];
                end
                `UBD_IDX_SCRATCH: begin
                    d.scratch = pwdata_i[7:0];
                end
                `UBD_IDX_MODE: begin
                    d.mode = pwdata_i[`UBD_MODE_EXT] ? UBD_EXTENDED
                                                     : UBD_LEGACY;
                end
                default: begin
                end
            endcase
        end
        // holding byte taken: the event set beats a data write clear
        if (!q.fifo_en && q.tx_valid && tx_ready_i) begin
            d.thr_ev = 1'b1;
        end
        // receiver loads holding register; arrival beats a read clear
        if (rx_valid_i && !q.fifo_en) begin
            d.rx_hold = rx_data_i;
            d.rx_full = 1'b1;
        end
        // upper enables are reserved outside extended mode
        if (d.mode == UBD_LEGACY) begin
            d.irqen[7:4] = 4'h0;
        end
        d.irq = |en;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            q          <= '0;
            q.irqen    <= `UBD_RST_BYTE;
            q.mode     <= UBD_LEGACY;
            q.fifo_en  <= 1'b0;
            q.thr_ev   <= 1'b0;
            q.prdata   <= `UBD_RST_WORD;
        end else begin
            q <= d;
        end
    end

    assign pready_o        = q.pready;
    assign pslverr_o       = q.pslverr;
    assign prdata_o        = q.prdata;
    assign rx_pop_o        = q.rx_pop;
    assign tx_valid_o      = q.tx_valid;
    assign tx_push_o       = q.tx_push;
    assign tx_data_o       = q.tx_hold;
    assign fifo_enable_o   = q.fifo_en;
    assign extended_o      = ext;
    assign line_control_o  = q.linectl;
    assign modem_control_o = q.modemctl;
    assign irq_o           = q.irq;

    // ******************************************************
    // checks
    // ******************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        psel_i && !penable_i;
    endsequence

    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence

    apb_wait_state_a: assert property (
        s_setup ##1 s_access |=> pready_o
    ) else $error("pready not one cycle after access");

    irq_reserved_a: assert property (
        !extended_o |-> q.irqen[7:4] == 4'h0
    ) else $error("reserved enables set in legacy mode");

    irq_follow_a: assert property (
        1'b1 |=> (irq_o == (|$past(en)))
    ) else $error("interrupt output does not follow enabled events");

    hold_read_a: assert property (
        s_access and (!pwrite_i && idx == `UBD_IDX_DATA && !fifo_enable_o
        && !bad) |=> prdata_o[7:0] == $past(q.rx_hold)
    ) else $error("data read did not return holding byte");

    tx_hold_a: assert property (
        done && pwrite_i && pstrb_i[0] && idx == `UBD_IDX_DATA
        && !fifo_enable_o |=> tx_valid_o && tx_data_o == $past(pwdata_i[7:0])
    ) else $error("data write did not load holding byte");

    tx_push_a: assert property (
        done && pwrite_i && pstrb_i[0] && idx == `UBD_IDX_DATA
        && fifo_enable_o |=> tx_push_o ##1 !tx_push_o
    ) else $error("queue push not a single pulse");

    ls_priority_a: assert property (
        s_access and (!pwrite_i && idx == `UBD_IDX_EVID && !extended_o
        && en[`UBD_IE_LS]) |=> prdata_o[3:0] == `UBD_EV_LS
    ) else $error("line status not reported first");

    ext_rx_irq_a: assert property (
        extended_o && q.irqen[0] && fifo_enable_o && rx_timeout_i |=> irq_o
    ) else $error("receive time-out did not raise interrupt");

    ier_write_a: assert property (
        done && pwrite_i && pstrb_i[0] && idx == `UBD_IDX_IRQEN
        && extended_o |=> q.irqen == $past(pwdata_i[7:0])
    ) else $error("enable write not stored");

endmodule : ubd_top

// *** ubd_partner.sv ***
// far-side model: transmitter, receiver and external queues
`timescale 1ns/1ps

module ubd_partner (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // from the block
    input  wire logic       tx_valid_i,
    input  wire logic       tx_push_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       rx_pop_i,
    // to the block
    output logic            tx_ready_o     = 1'b0,
    output logic            rx_valid_o     = 1'b0,
    output logic [7:0]      rx_data_o      = 8'h00,
    output logic [7:0]      rx_fifo_data_o = 8'h00
);
    int         delay   = 0;
    int         wait_q  = 0;
    int         pushes  = 0;
    int         pops    = 0;
    logic [7:0] last_tx = 8'h00;

    // ready is one cycle wide, after a programmable stall
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ready_o <= 1'b0;
            wait_q     <= 0;
        end else begin
            tx_ready_o <= 1'b0;
            if (tx_valid_i && !tx_ready_o) begin
                wait_q <= wait_q + 1;
                if (wait_q >= delay) begin
                    tx_ready_o <= 1'b1;
                    wait_q     <= 0;
                end
            end
            if (tx_valid_i && tx_ready_o) begin
                last_tx <= tx_data_i;
            end
            if (tx_push_i) begin
                pushes++;
                last_tx <= tx_data_i;
            end
            // head gone: the line no longer shows the old byte
            if (rx_pop_i) begin
                pops++;
                rx_fifo_data_o <= ~rx_fifo_data_o;
            end
        end
    end

    task send_rx(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o  <= b;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~b;
    endtask : send_rx

    task load_head(input logic [7:0] b);
        rx_fifo_data_o <= b;
    endtask : load_head

endmodule : ubd_partner

// *** tb.sv ***
// self-checking bench for the bank 0 register block
`timescale 1ns/1ps

module tb;
    logic        clk_i   = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel_i  = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [7:0]  paddr_i   = 8'h00;
    logic [31:0] pwdata_i  = 32'h0;
    logic [3:0]  pstrb_i   = 4'h0;
    logic [3:0]  src       = 4'h0;
    logic [7:0]  ls_val    = 8'h61;
    logic [7:0]  ms_val    = 8'hB0;
    logic        tx_low    = 1'b0;
    logic        tx_emp    = 1'b0;
    logic        pready_o, pslverr_o, rx_pop_o, tx_ready, rx_valid, tx_valid_o, tx_push_o;
    logic        fifo_enable_o, extended_o, irq_o;
    logic [31:0] prdata_o, rd;
    logic [7:0]  rx_data, rx_fifo_data, tx_data_o, line_control_o, modem_control_o;
    logic        err;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          cycles      = 0;
    int          n;
    logic [7:0]  codes [4] = '{8'hC4, 8'hCC, 8'hC6, 8'hC0};
    logic [7:0]  ebits [4] = '{8'h01, 8'h01, 8'h04, 8'h08};

    always #5 clk_i = ~clk_i;

    ubd_top #(.AW(8)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
        .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_fifo_data_i(rx_fifo_data),
        .rx_pop_o(rx_pop_o), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid_o),
        .tx_push_o(tx_push_o), .tx_data_o(tx_data_o), .rx_level_i(src[0]),
        .rx_timeout_i(src[1]), .tx_low_i(tx_low), .tx_empty_i(tx_emp),
        .line_status_event_i(src[2]), .modem_status_event_i(src[3]),
        .line_status_i(ls_val), .modem_status_i(ms_val), .fifo_enable_o(fifo_enable_o),
        .extended_o(extended_o), .line_control_o(line_control_o),
        .modem_control_o(modem_control_o), .irq_o(irq_o));

    ubd_partner i_part (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_o), .tx_push_i(tx_push_o),
        .tx_data_i(tx_data_o), .rx_pop_i(rx_pop_o), .tx_ready_o(tx_ready),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_fifo_data_o(rx_fifo_data));

    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task chk_data(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk_data

    task chk_pin(input logic got, input logic exp);
        chk_data({31'h0, got}, {31'h0, exp});
    endtask : chk_pin

    // ********************
    // apb master
    // ********************
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= {24'h0, d};
        pstrb_i   <= w ? 4'hF : 4'h0;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk_data(rd, exp);
    endtask : rd_chk

    task settle;
        repeat (2) @(posedge clk_i);
    endtask : settle

    task end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd_chk(8'h04, 32'h00);
        rd_chk(8'h20, 32'h00);
        rd_chk(8'h08, 32'h01);
        chk_pin(fifo_enable_o, 1'b0);
        chk_pin(extended_o, 1'b0);
        end_test("reset");
        wr(8'h04, 8'hFF);
        rd_chk(8'h04, 32'h0F);
        wr(8'h20, 8'h01);
        chk_pin(extended_o, 1'b1);
        wr(8'h04, 8'h21);
        rd_chk(8'h04, 32'h21);
        tx_emp <= 1'b1;
        rd_chk(8'h08, 32'h22);
        tx_emp <= 1'b0;
        wr(8'h08, 8'h01);
        src <= 4'h1;
        settle();
        chk_pin(irq_o, 1'b1);
        src <= 4'h2;
        settle();
        chk_pin(irq_o, 1'b1);
        src <= 4'h0;
        wr(8'h08, 8'h00);
        wr(8'h20, 8'h00);
        rd_chk(8'h04, 32'h01);
        wr(8'h04, 8'h00);
        end_test("enables");
        wr(8'h08, 8'h01);
        for (int i = 0; i < 4; i++) begin
            src <= 4'h1 << i;
            settle();
            chk_pin(irq_o, 1'b0);
            wr(8'h04, ebits[i]);
            settle();
            chk_pin(irq_o, 1'b1);
            rd_chk(8'h08, {24'h0, codes[i]});
            wr(8'h04, 8'h00);
            src <= 4'h0;
            settle();
        end
        wr(8'h04, 8'h0D);
        src <= 4'hF;
        settle();
        rd_chk(8'h08, 32'hC6);
        src <= 4'hB;
        settle();
        rd_chk(8'h08, 32'hC4);
        src <= 4'h8;
        settle();
        rd_chk(8'h08, 32'hC0);
        src <= 4'h0;
        settle();
        rd_chk(8'h08, 32'hC1);
        chk_pin(irq_o, 1'b0);
        wr(8'h08, 8'h00);
        end_test("events");
        i_part.send_rx(8'hA5);
        settle();
        rd_chk(8'h08, 32'h04);
        rd_chk(8'h00, 32'hA5);
        rd_chk(8'h08, 32'h01);
        i_part.delay = 3;
        wr(8'h04, 8'h02);
        wr(8'h00, 8'h3C);
        chk_pin(tx_valid_o, 1'b1);
        while (tx_valid_o !== 1'b0) begin
            @(posedge clk_i);
        end
        chk_data({24'h0, i_part.last_tx}, 32'h3C);
        settle();
        chk_pin(irq_o, 1'b1);
        rd_chk(8'h08, 32'h02);
        rd_chk(8'h08, 32'h01);
        wr(8'h04, 8'h00);
        end_test("holding");
        wr(8'h08, 8'h01);
        chk_pin(fifo_enable_o, 1'b1);
        rd_chk(8'h08, 32'hC1);
        tx_low <= 1'b1;
        wr(8'h04, 8'h02);
        rd_chk(8'h08, 32'hC2);
        wr(8'h04, 8'h00);
        tx_low <= 1'b0;
        n = i_part.pushes;
        wr(8'h00, 8'h5A);
        settle();
        chk_data(i_part.pushes, n + 1);
        chk_data({24'h0, i_part.last_tx}, 32'h5A);
        i_part.load_head(8'h77);
        n = i_part.pops;
        rd_chk(8'h00, 32'h77);
        settle();
        chk_data(i_part.pops, n + 1);
        wr(8'h08, 8'h00);
        end_test("queues");
        wr(8'h0C, 8'h1B);
        wr(8'h10, 8'h13);
        wr(8'h1C, 8'hC3);
        chk_data({24'h0, line_control_o}, 32'h1B);
        chk_data({24'h0, modem_control_o}, 32'h13);
        rd_chk(8'h1C, 32'hC3);
        rd_chk(8'h14, 32'h61);
        rd_chk(8'h18, 32'hB0);
        apb(1'b0, 8'h24, 8'h00);
        chk_pin(err, 1'b1);
        chk_data(rd, 32'h0);
        apb(1'b1, 8'h05, 8'hFF);
        chk_pin(err, 1'b1);
        rd_chk(8'h04, 32'h00);
        end_test("map");
        print_verdict();
    end

endmodule : tb
